// ==== design/bisv_pkg.sv ====
// constants and types shared by the board interrupt and bus supervisor
package bisv_pkg;
  // clocks: reference 200 MHz, board system clock 25 MHz
  localparam int REF_CLK_PERIOD_PS = 5000;
  localparam int SYS_CLK_PERIOD_PS = 40000;
  localparam int SYS_CLK_DIV = SYS_CLK_PERIOD_PS / REF_CLK_PERIOD_PS;
  localparam int DIV_W = $clog2(SYS_CLK_DIV);
  // bus monitor period after reset, in system clock cycles
  localparam int BMON_DEFAULT_CYCLES = 1024;
  localparam int BMON_W = 12;
  localparam logic [BMON_W-1:0] BMON_RST = BMON_W'(BMON_DEFAULT_CYCLES);
  // cache shield region is at most 32K bytes
  localparam int SHIELD_MAX_BYTES = 32768;
  localparam int SHIELD_MASK_W = $clog2(SHIELD_MAX_BYTES);
  // breakpoint control word: attribute value and enable bit
  localparam int BREAKPOINT_CONTROL_REG_ATTR_W = 8;
  localparam int BREAKPOINT_CONTROL_REG_EN_POS = 8;
  localparam int BREAKPOINT_CONTROL_REG_W = 9;
  // priority levels
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_HOST = 3'h2;
  localparam logic [2:0] LVL_PARITY = 3'h5;
  localparam logic [2:0] LVL_NMI = 3'h7;
  // synchronised pin positions and their idle values after reset
  localparam int PIN_N = 6;
  localparam int PIN_ABORT_N = 0;
  localparam int PIN_BRK = 1;
  localparam int PIN_PARITY_N = 2;
  localparam int PIN_HREQ = 3;
  localparam int PIN_HACK = 4;
  localparam int PIN_SEL = 5;
  localparam logic [PIN_N-1:0] PIN_RST = 6'h05;
  typedef enum logic [0:0] {
    ROUTE_IRQ = 1'b0,
    ROUTE_SHIELD = 1'b1
  } bisv_route_t;
  typedef enum logic [1:0] {
    OWN_CPU = 2'b00,
    OWN_SERIAL_DMA_ENGINE = 2'b01,
    OWN_EXT = 2'b10
  } bisv_owner_t;
endpackage

// ==== design/bisv_supervisor.sv ====
// board interrupt encoder, arbiter, breakpoint, bus monitor and watchdog
//
// Notes on behaviour
// - all interrupt requests merge into one active-low three-bit level output
// - abort button press raises non-maskable level 7
// - host break assert then release raises level 7 and sets host-NMI flag
// - breakpoint routed to interrupts raises level 7, sets breakpoint flag
// - every level 7 source is latched; host-NMI and breakpoint flags readable
// - parity failure on memory read drives maskable level 5
// - host request or acknowledge while selected raises maskable level 2
// - levels 5 and 2 are acknowledged by autovector
// - processor keeps bus grant while no other master needs the bus
// - bus never leaves processor during a locked sequence
// - serial DMA outranks the external bus request
// - at transfer start compare address and attributes, assert breakpoint
// - only the transfer start beat is compared, not burst beats
// - breakpoint acknowledge cycles get no answer; bus monitor ends them
// - unterminated cycles end with transfer error or internal bus fault
// - bus monitor period is 1K system clock cycles after reset
// - unanswered acknowledge on internally served level ends with error
// - watchdog off after reset; once enabled, resets unless serviced
// - shield routing inhibits caching of matching line reads, region <=32K
// - breakpoint serves interrupt or shield, selected by one routing input
module bisv_supervisor
  import bisv_pkg::*;
#(
  parameter int WDOG_TIMEOUT = 65536,
  parameter logic [7:0] INT_LEVEL_MASK = 8'hA4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // board pins, asynchronous
  input wire logic abort_n_i,
  input wire logic host_break_line_i,
  input wire logic parity_fail_n_i,
  input wire logic host_req_i,
  input wire logic host_ack_i,
  input wire logic board_sel_i,
  // interrupt control and status
  input wire logic [2:0] internal_irq_level_i,
  input wire logic level5_en_i,
  input wire logic level2_en_i,
  input wire logic l7_clear_i,
  input wire logic bkpt_route_i,
  output logic [2:0] encoded_irq_level_n_o,
  output logic host_nmi_flag_n_o,
  output logic brkpoint_int_flag_n_o,
  output logic autovector_o,
  // processor bus cycle
  input wire logic transfer_start_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [BREAKPOINT_CONTROL_REG_ATTR_W-1:0] attr_i,
  input wire logic iack_cycle_i,
  input wire logic bkpt_ack_cycle_i,
  input wire logic [2:0] iack_level_i,
  input wire logic transfer_ack_n_i,
  output logic transfer_error_n_o,
  // internal master cycle
  input wire logic int_cycle_start_i,
  input wire logic internal_size_ack_n_i,
  output logic internal_bus_fault_n_o,
  // breakpoint
  input wire logic [31:0] breakpoint_address_reg_i,
  input wire logic [SHIELD_MASK_W-1:0] breakpoint_mask_i,
  input wire logic [BREAKPOINT_CONTROL_REG_W-1:0] breakpoint_control_reg_i,
  output logic breakpoint_out_n_o,
  output logic cache_inhibit_in_n_o,
  // bus monitor programming
  input wire logic [BMON_W-1:0] bmon_limit_i,
  input wire logic bmon_load_i,
  // arbitration
  input wire logic lock_n_i,
  input wire logic serial_dma_req_i,
  input wire logic bus_request_n_i,
  output logic bus_grant_n_o,
  output logic serial_dma_grant_o,
  output logic ext_grant_n_o,
  // software watchdog
  input wire logic wdog_enable_i,
  input wire logic wdog_service_i,
  output logic wdog_reset_o
);
  localparam int WDOG_W = $clog2(WDOG_TIMEOUT + 1);

  if (WDOG_TIMEOUT < 2) begin : g_chk
    $error("WDOG_TIMEOUT must be at least 2");
  end

  function automatic logic [2:0] max_lvl(input logic [2:0] a,
                                         input logic [2:0] b);
    max_lvl = (a > b) ? a : b;
  endfunction

  // pin synchronisers
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic [PIN_N-1:0] pin_prev;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= PIN_RST;
      pin_sync <= PIN_RST;
      pin_prev <= PIN_RST;
    end else begin
      pin_meta <= {board_sel_i, host_ack_i, host_req_i, parity_fail_n_i,
                   host_break_line_i, abort_n_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // interrupt sources, breakpoint and level encoding
  logic ts;
  logic bkpt_hit;
  logic abort_flag, next_abort_flag;
  logic hnmi_flag, next_hnmi_flag;
  logic brkpoint_int_flag_flag, next_brkpoint_int_flag_flag;
  logic [2:0] irq_level, next_irq_level;
  logic bkpt_q, next_bkpt_q;
  logic l7_any;
  assign ts = ~transfer_start_n_i;
  assign l7_any = abort_flag | hnmi_flag | brkpoint_int_flag_flag;

  always_comb begin
    logic [31:0] care;
    logic abort_press;
    logic brk_release;
    logic [2:0] lvl;
    care = ~{{(32-SHIELD_MASK_W){1'b0}}, breakpoint_mask_i};
    abort_press = pin_prev[PIN_ABORT_N] & ~pin_sync[PIN_ABORT_N];
    brk_release = pin_prev[PIN_BRK] & ~pin_sync[PIN_BRK];
    // only the start beat is looked at; burst beats carry no start
    bkpt_hit = ts & breakpoint_control_reg_i[BREAKPOINT_CONTROL_REG_EN_POS]
      & ((addr_i & care) == (breakpoint_address_reg_i & care))
      & (attr_i == breakpoint_control_reg_i[BREAKPOINT_CONTROL_REG_ATTR_W-1:0]);
    next_bkpt_q = bkpt_hit;
    // a new event outweighs a clear in the same cycle
    next_abort_flag = (abort_flag & ~l7_clear_i) | abort_press;
    next_hnmi_flag = (hnmi_flag & ~l7_clear_i) | brk_release;
    next_brkpoint_int_flag_flag = (brkpoint_int_flag_flag & ~l7_clear_i)
      | (bkpt_hit & (bkpt_route_i == ROUTE_IRQ));
    lvl = internal_irq_level_i;
    if (level5_en_i && !pin_sync[PIN_PARITY_N]) begin
      lvl = max_lvl(lvl, LVL_PARITY);
    end
    if (level2_en_i && pin_sync[PIN_SEL]
        && (pin_sync[PIN_HREQ] || pin_sync[PIN_HACK])) begin
      lvl = max_lvl(lvl, LVL_HOST);
    end
    if (l7_any) begin
      lvl = LVL_NMI;
    end
    next_irq_level = lvl;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      abort_flag <= 1'b0;
      hnmi_flag <= 1'b0;
      brkpoint_int_flag_flag <= 1'b0;
      irq_level <= LVL_NONE;
      bkpt_q <= 1'b0;
    end else begin
      abort_flag <= next_abort_flag;
      hnmi_flag <= next_hnmi_flag;
      brkpoint_int_flag_flag <= next_brkpoint_int_flag_flag;
      irq_level <= next_irq_level;
      bkpt_q <= next_bkpt_q;
    end
  end

  assign encoded_irq_level_n_o = ~irq_level;
  assign host_nmi_flag_n_o = ~hnmi_flag;
  assign brkpoint_int_flag_n_o = ~brkpoint_int_flag_flag;
  assign breakpoint_out_n_o = ~bkpt_q;
  assign cache_inhibit_in_n_o =
    ~(bkpt_q & (bkpt_route_i == ROUTE_SHIELD));

  // system clock divider and bus monitor
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic sys_tick;
  logic cyc_cpu, next_cyc_cpu;
  logic cyc_int, next_cyc_int;
  logic [BMON_W-1:0] bmon_cnt, next_bmon_cnt;
  logic [BMON_W-1:0] bmon_limit, next_bmon_limit;
  logic tea, next_tea;
  logic internal_bus_fault, next_internal_bus_fault;
  logic autovec, next_autovec;
  assign sys_tick = (div_cnt == DIV_W'(SYS_CLK_DIV - 1));

  always_comb begin
    logic expire;
    logic served;
    served = INT_LEVEL_MASK[iack_level_i];
    expire = sys_tick && (bmon_cnt + 1'b1 >= bmon_limit);
    next_div_cnt = sys_tick ? '0 : div_cnt + 1'b1;
    next_bmon_limit = bmon_load_i ? bmon_limit_i : bmon_limit;
    next_cyc_cpu = cyc_cpu;
    next_cyc_int = cyc_int;
    next_bmon_cnt = bmon_cnt;
    next_tea = 1'b0;
    next_internal_bus_fault = 1'b0;
    next_autovec = 1'b0;
    if ((cyc_cpu || cyc_int) && sys_tick) begin
      next_bmon_cnt = bmon_cnt + 1'b1;
    end
    if (cyc_cpu && expire) begin
      next_tea = 1'b1;
      next_cyc_cpu = 1'b0;
    end
    if (cyc_int && expire) begin
      next_internal_bus_fault = 1'b1;
      next_cyc_int = 1'b0;
    end
    if (cyc_cpu && !transfer_ack_n_i) begin
      next_cyc_cpu = 1'b0;
    end
    if (cyc_int && !internal_size_ack_n_i) begin
      next_cyc_int = 1'b0;
    end
    if (ts) begin
      // a breakpoint acknowledge is left open for the monitor to end
      next_cyc_cpu = 1'b1;
      next_bmon_cnt = '0;
      if (iack_cycle_i && !bkpt_ack_cycle_i && served) begin
        if (iack_level_i == irq_level) begin
          next_autovec = 1'b1;
        end else begin
          next_tea = 1'b1;
        end
        next_cyc_cpu = 1'b0;
      end
    end
    if (int_cycle_start_i) begin
      next_cyc_int = 1'b1;
      next_bmon_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      cyc_cpu <= 1'b0;
      cyc_int <= 1'b0;
      bmon_cnt <= '0;
      bmon_limit <= BMON_RST;
      tea <= 1'b0;
      internal_bus_fault <= 1'b0;
      autovec <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      cyc_cpu <= next_cyc_cpu;
      cyc_int <= next_cyc_int;
      bmon_cnt <= next_bmon_cnt;
      bmon_limit <= next_bmon_limit;
      tea <= next_tea;
      internal_bus_fault <= next_internal_bus_fault;
      autovec <= next_autovec;
    end
  end

  assign transfer_error_n_o = ~tea;
  assign internal_bus_fault_n_o = ~internal_bus_fault;
  assign autovector_o = autovec;

  // arbiter: parks the bus on the processor
  bisv_owner_t owner, next_owner;
  always_comb begin
    logic can_switch;
    can_switch = lock_n_i && !cyc_cpu && !ts;
    next_owner = owner;
    if (owner == OWN_CPU) begin
      if (can_switch && serial_dma_req_i) begin
        next_owner = OWN_SERIAL_DMA_ENGINE;
      end else if (can_switch && !bus_request_n_i) begin
        next_owner = OWN_EXT;
      end
    end else if (!serial_dma_req_i && bus_request_n_i) begin
      next_owner = OWN_CPU;
    end else if (serial_dma_req_i) begin
      // dma outranks a waiting external master even mid-tenure
      next_owner = OWN_SERIAL_DMA_ENGINE;
    end else begin
      next_owner = OWN_EXT;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      owner <= OWN_CPU;
    end else begin
      owner <= next_owner;
    end
  end

  assign bus_grant_n_o = (owner != OWN_CPU);
  assign serial_dma_grant_o = (owner == OWN_SERIAL_DMA_ENGINE);
  assign ext_grant_n_o = (owner != OWN_EXT);

  // software watchdog, one-way enable until reset
  logic wdog_en, next_wdog_en;
  logic [WDOG_W-1:0] wdog_cnt, next_wdog_cnt;
  logic wdog_rst, next_wdog_rst;
  always_comb begin
    next_wdog_en = wdog_en | wdog_enable_i;
    next_wdog_cnt = wdog_cnt;
    next_wdog_rst = 1'b0;
    if (!wdog_en || wdog_service_i) begin
      next_wdog_cnt = '0;
    end else if (wdog_cnt == WDOG_W'(WDOG_TIMEOUT - 1)) begin
      next_wdog_rst = 1'b1;
      next_wdog_cnt = '0;
    end else begin
      next_wdog_cnt = wdog_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_en <= 1'b0;
      wdog_cnt <= '0;
      wdog_rst <= 1'b0;
    end else begin
      wdog_en <= next_wdog_en;
      wdog_cnt <= next_wdog_cnt;
      wdog_rst <= next_wdog_rst;
    end
  end

  assign wdog_reset_o = wdog_rst;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_nmi_level: assert property (l7_any |=>
    encoded_irq_level_n_o == ~LVL_NMI) else $error("level 7 not shown");
  a_host_nmi_flag: assert property ($fell(pin_sync[PIN_BRK])
    |=> !host_nmi_flag_n_o ##1 encoded_irq_level_n_o == ~LVL_NMI)
    else $error("host break not latched");
  a_bkpt_irq: assert property (bkpt_hit && bkpt_route_i == ROUTE_IRQ
    |=> !brkpoint_int_flag_n_o && !breakpoint_out_n_o)
    else $error("breakpoint flag missing");
  a_shield_excl: assert property (bkpt_route_i == ROUTE_IRQ
    |-> cache_inhibit_in_n_o) else $error("shield active in irq route");
  a_parity_lvl: assert property (!l7_any && level5_en_i
    && !pin_sync[PIN_PARITY_N] && internal_irq_level_i <= LVL_PARITY
    |=> encoded_irq_level_n_o == ~LVL_PARITY) else $error("no level 5");
  a_bus_park: assert property (!serial_dma_req_i && bus_request_n_i
    |=> !bus_grant_n_o) else $error("bus not parked");
  a_lock_hold: assert property (!lock_n_i && !bus_grant_n_o
    |=> !bus_grant_n_o) else $error("bus lost during lock");
  a_serial_dma_engine_first: assert property (owner == OWN_CPU && lock_n_i
    && !cyc_cpu && !ts && serial_dma_req_i && !bus_request_n_i
    |=> serial_dma_grant_o && ext_grant_n_o) else $error("dma lost");
  a_bmon_expire: assert property (cyc_cpu && sys_tick && !ts
    && transfer_ack_n_i && bmon_cnt + 1'b1 >= bmon_limit
    |=> !transfer_error_n_o) else $error("monitor did not expire");
  a_spur_iack: assert property (ts && iack_cycle_i && !bkpt_ack_cycle_i
    && INT_LEVEL_MASK[iack_level_i] && iack_level_i != irq_level
    |=> !transfer_error_n_o ##1 transfer_error_n_o)
    else $error("spurious iack not ended");
  a_wdog_off: assert property (!wdog_en |-> ##1 !wdog_reset_o)
    else $error("watchdog fired while off");

  c_abort: cover property ($rose(abort_flag));
  c_shield: cover property (!cache_inhibit_in_n_o);
  c_bmon: cover property (!internal_bus_fault_n_o);
  c_ext_grant: cover property (!ext_grant_n_o);
endmodule

// ==== verification/bisv_cpu_model.sv ====
// processor core model: priority lines in, bus cycle starts out
module bisv_cpu_model
  import bisv_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // priority from the supervisor
  input wire logic [2:0] encoded_irq_level_n_i,
  // bus cycle
  output logic transfer_start_n_o,
  output logic [31:0] addr_o,
  output logic [BREAKPOINT_CONTROL_REG_ATTR_W-1:0] attr_o,
  output logic iack_o,
  output logic bkpt_ack_o,
  output logic [2:0] iack_level_o,
  output logic [2:0] ipl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign ipl_o = ~encoded_irq_level_n_i;
  initial begin
    transfer_start_n_o = 1'b1;
    {addr_o, attr_o, iack_o, bkpt_ack_o, iack_level_o} = '1;
  end
  // burst beats keep the address with no start; then the inverse is
  // shown so a stale address can never match by accident
  task automatic bus(input logic [31:0] a, input logic [7:0] t,
      input logic ia, bk, input logic [2:0] lv, input int beats);
    @(negedge ref_clk_i);
    transfer_start_n_o = 1'b0;
    {addr_o, attr_o, iack_o, bkpt_ack_o, iack_level_o} = {a, t, ia, bk, lv};
    @(negedge ref_clk_i);
    transfer_start_n_o = 1'b1;
    repeat (beats) @(negedge ref_clk_i);
    {addr_o, attr_o, iack_o, bkpt_ack_o, iack_level_o} = ~{a, t, ia, bk, lv};
  endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the board interrupt and bus supervisor
module tb_top
  import bisv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_i, abort_n_i, host_break_line_i, parity_fail_n_i;
  logic host_req_i, host_ack_i, board_sel_i, level5_en_i, level2_en_i;
  logic l7_clear_i, bkpt_route_i, transfer_ack_n_i, int_cycle_start_i;
  logic internal_size_ack_n_i, bmon_load_i, lock_n_i, serial_dma_req_i;
  logic bus_request_n_i, wdog_enable_i, wdog_service_i;
  logic [2:0] internal_irq_level_i, encoded_irq_level_n_o, iack_level_i;
  logic host_nmi_flag_n_o, brkpoint_int_flag_n_o, autovector_o;
  logic transfer_start_n_i, iack_cycle_i, bkpt_ack_cycle_i;
  logic transfer_error_n_o, internal_bus_fault_n_o, breakpoint_out_n_o;
  logic cache_inhibit_in_n_o, bus_grant_n_o, serial_dma_grant_o;
  logic ext_grant_n_o, wdog_reset_o, hit;
  logic [2:0] ipl;
  logic [31:0] addr_i, breakpoint_address_reg_i, r, a;
  logic [BREAKPOINT_CONTROL_REG_ATTR_W-1:0] attr_i;
  logic [SHIELD_MASK_W-1:0] breakpoint_mask_i;
  logic [BREAKPOINT_CONTROL_REG_W-1:0] breakpoint_control_reg_i;
  logic [BMON_W-1:0] bmon_limit_i;
  int n_mismatch = 0, n_compared = 0, seed, n;
  int cnt[6] = '{default: 0};
  int base[6];

  bisv_supervisor #(.WDOG_TIMEOUT(16)) bisv_supervisor_i (
    .ref_clk_i, .rst_i, .abort_n_i, .host_break_line_i, .parity_fail_n_i,
    .host_req_i, .host_ack_i, .board_sel_i, .internal_irq_level_i,
    .level5_en_i, .level2_en_i, .l7_clear_i, .bkpt_route_i,
    .encoded_irq_level_n_o, .host_nmi_flag_n_o, .brkpoint_int_flag_n_o,
    .autovector_o, .transfer_start_n_i, .addr_i, .attr_i, .iack_cycle_i,
    .bkpt_ack_cycle_i, .iack_level_i, .transfer_ack_n_i,
    .transfer_error_n_o, .int_cycle_start_i, .internal_size_ack_n_i,
    .internal_bus_fault_n_o, .breakpoint_address_reg_i, .breakpoint_mask_i,
    .breakpoint_control_reg_i, .breakpoint_out_n_o, .cache_inhibit_in_n_o,
    .bmon_limit_i, .bmon_load_i, .lock_n_i, .serial_dma_req_i,
    .bus_request_n_i, .bus_grant_n_o, .serial_dma_grant_o, .ext_grant_n_o,
    .wdog_enable_i, .wdog_service_i, .wdog_reset_o
  );
  bisv_cpu_model bisv_cpu_model_i (
    .ref_clk_i, .encoded_irq_level_n_i(encoded_irq_level_n_o),
    .transfer_start_n_o(transfer_start_n_i), .addr_o(addr_i),
    .attr_o(attr_i), .iack_o(iack_cycle_i), .bkpt_ack_o(bkpt_ack_cycle_i),
    .iack_level_o(iack_level_i), .ipl_o(ipl)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // one-cycle pulse counters: 0 bkpt 1 inhibit 2 tea 3 autovec 4 internal_bus_fault 5 wdog
  always @(posedge ref_clk_i) begin
    cnt[0] += (breakpoint_out_n_o === 1'b0);
    cnt[1] += (cache_inhibit_in_n_o === 1'b0);
    cnt[2] += (transfer_error_n_o === 1'b0);
    cnt[3] += (autovector_o === 1'b1);
    cnt[4] += (internal_bus_fault_n_o === 1'b0);
    cnt[5] += (wdog_reset_o === 1'b1);
  end

  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int i, input logic [31:0] exp);
    chk(cnt[i] - base[i], exp);
  endtask
  task automatic chk_lvl(input logic [2:0] exp);
    chk(encoded_irq_level_n_o, 3'(~exp));
  endtask
  task automatic chk_own(input logic [2:0] exp);
    chk({bus_grant_n_o, serial_dma_grant_o, ext_grant_n_o}, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  task automatic tog(ref logic s);
    s = ~s;
    cyc(1);
    s = ~s;
  endtask
  task automatic wait_cnt(input int i, lim);
    n = 0;
    while (cnt[i] == base[i] && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic logic [2:0] exp_lvl(input logic [2:0] il,
      input logic p5, p2);
    exp_lvl = il;
    if (p5 && il < LVL_PARITY) exp_lvl = LVL_PARITY;
    else if (p2 && il < LVL_HOST) exp_lvl = LVL_HOST;
  endfunction
  task automatic summarize();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  initial begin
    seed = 32'hCCC8;
    rst_i = 1'b1;
    {abort_n_i, parity_fail_n_i, transfer_ack_n_i} = 3'h7;
    {internal_size_ack_n_i, lock_n_i, bus_request_n_i} = 3'h7;
    {host_break_line_i, host_req_i, host_ack_i, board_sel_i} = 4'h0;
    {level5_en_i, level2_en_i, l7_clear_i, bkpt_route_i} = 4'h0;
    {int_cycle_start_i, bmon_load_i, serial_dma_req_i} = 3'h0;
    {wdog_enable_i, wdog_service_i, internal_irq_level_i} = 5'h00;
    {breakpoint_address_reg_i, breakpoint_mask_i} = 47'h0;
    {breakpoint_control_reg_i, bmon_limit_i} = 21'h0;
    repeat (16) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    cyc(1);
    chk_lvl(LVL_NONE);
    chk({host_nmi_flag_n_o, brkpoint_int_flag_n_o}, 2'h3);
    chk_own(3'h1);
    base = cnt;
    // unanswered cycle under the period left by reset
    bisv_cpu_model_i.bus($random(seed), 8'h00, 1'b0, 1'b0, 3'h0, 0);
    wait_cnt(2, 9000);
    chk(n >= 8176 && n <= 8210, 1'b1);
    chk_cnt(5, 0);
    bmon_limit_i = 12'h004;
    tog(bmon_load_i);
    base = cnt;
    tog(int_cycle_start_i);
    cyc(3);
    tog(internal_size_ack_n_i);
    cyc(60);
    chk_cnt(4, 0);
    tog(int_cycle_start_i);
    wait_cnt(4, 100);
    chk(n >= 22 && n <= 44, 1'b1);
    base = cnt;
    bisv_cpu_model_i.bus(32'h0, 8'h00, 1'b0, 1'b1, 3'h7, 0);
    cyc(3);
    chk_cnt(2, 0);
    wait_cnt(2, 100);
    chk_cnt(2, 1);
    chk_cnt(3, 0);
    base = cnt;
    bisv_cpu_model_i.bus(32'h0, 8'h00, 1'b1, 1'b0, LVL_PARITY, 0);
    cyc(2);
    chk_cnt(2, 1);
    // level 3 is not served here, so only the memory side ends it
    bisv_cpu_model_i.bus(32'h0, 8'h00, 1'b1, 1'b0, 3'h3, 0);
    cyc(2);
    chk_cnt(2, 1);
    tog(transfer_ack_n_i);
    {parity_fail_n_i, level5_en_i} = 2'b01;
    cyc(8);
    chk_lvl(LVL_PARITY);
    base = cnt;
    bisv_cpu_model_i.bus(32'h0, 8'h00, 1'b1, 1'b0, ipl, 0);
    cyc(2);
    chk_cnt(3, 1);
    chk_cnt(2, 0);
    parity_fail_n_i = 1'b1;
    abort_n_i = 1'b0;
    cyc(6);
    abort_n_i = 1'b1;
    cyc(2);
    chk_lvl(LVL_NMI);
    // no readable flag, so software blames the button
    chk({host_nmi_flag_n_o, brkpoint_int_flag_n_o}, 2'h3);
    tog(l7_clear_i);
    cyc(2);
    chk_lvl(LVL_NONE);
    tog(host_break_line_i);
    cyc(6);
    chk_lvl(LVL_NMI);
    chk(host_nmi_flag_n_o, 1'b0);
    tog(l7_clear_i);
    // first pass: level 5 masked under a pending 4
    for (int i = 0; i < 16; i++) begin
      r = i ? $random(seed) : 32'h1E4;
      {level2_en_i, board_sel_i, host_ack_i, host_req_i} = r[8:5];
      {level5_en_i, parity_fail_n_i, internal_irq_level_i} = r[4:0];
      cyc(8);
      chk_lvl(exp_lvl(r[2:0], !r[3] && r[4],
          |r[6:5] && &r[8:7]));
    end
    {board_sel_i, parity_fail_n_i, internal_irq_level_i} = 5'h08;
    breakpoint_control_reg_i = 9'h15A;
    breakpoint_mask_i = 15'h00FF;
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      a = $random(seed);
      breakpoint_address_reg_i = a;
      bkpt_route_i = r[2];
      if (r[1:0] == 2'h1) a[31] = !a[31];
      if (r[1:0] == 2'h2) a[3] = !a[3];
      hit = !r[0];
      base = cnt;
      bisv_cpu_model_i.bus(a, r[1:0] == 2'h3 ? 8'hA5 : 8'h5A, 1'b0, 1'b0,
          3'h0, 3);
      tog(transfer_ack_n_i);
      cyc(3);
      chk_cnt(0, hit);
      chk_cnt(1, hit && r[2]);
      chk(brkpoint_int_flag_n_o, !(hit && !r[2]));
      tog(l7_clear_i);
    end
    // a second 16M block address off the breakpoint gets no cache inhibit
    base = cnt;
    bisv_cpu_model_i.bus({8'h01, a[23:0]}, 8'h00, 1'b0, 1'b0, 3'h0, 0);
    tog(transfer_ack_n_i);
    cyc(2);
    chk_cnt(1, 0);
    {serial_dma_req_i, bus_request_n_i} = 2'b10;
    cyc(3);
    chk_own(3'h7);
    serial_dma_req_i = 1'b0;
    cyc(4);
    chk_own(3'h4);
    bus_request_n_i = 1'b1;
    cyc(3);
    chk_own(3'h1);
    {lock_n_i, serial_dma_req_i} = 2'b01;
    cyc(5);
    chk_own(3'h1);
    lock_n_i = 1'b1;
    cyc(3);
    chk_own(3'h7);
    serial_dma_req_i = 1'b0;
    cyc(3);
    chk_own(3'h1);
    tog(wdog_enable_i);
    base = cnt;
    repeat (5) begin
      cyc(10);
      tog(wdog_service_i);
    end
    chk_cnt(5, 0);
    cyc(20);
    chk_cnt(5, 1);
    summarize();
  end
endmodule
